// ===== hdl/phy_status_pkg.sv
// Purpose: shared constants for the status summary and interrupt control bank
// Assumes: 5-bit management register index, 16-bit register data
// Notes: offsets are management register indices on the plain register port
package phy_status_pkg;
   localparam int DATA_W = 16;
   localparam int ADDR_W = 5;

   // register indices
   localparam logic [4:0] ADDR_BASIC_MODE_STATUS = 5'h01;
   localparam logic [4:0] ADDR_AUTONEG_EXPANSION = 5'h06;
   localparam logic [4:0] ADDR_STATUS_SUMMARY = 5'h10;
   localparam logic [4:0] ADDR_INTERRUPT_CONTROL = 5'h11;
   localparam logic [4:0] ADDR_INTERRUPT_EVENT_STATUS = 5'h12;
   localparam logic [4:0] ADDR_PHY_CONFIG = 5'h16;

   ////////////////////////////////////////////////////////////////////////////
   // status summary field positions
   localparam int SUM_SIG_DET_QUAL = 10;
   localparam int SUM_DESCR_LOCK = 9;
   localparam int SUM_PAGE_RX = 8;
   localparam int SUM_IRQ_PEND = 7;
   localparam int SUM_REM_FAULT = 6;
   localparam int SUM_JABBER = 5;
   localparam int SUM_AN_DONE = 4;
   localparam int SUM_LOOPBACK = 3;
   localparam int SUM_DUPLEX = 2;
   localparam int SUM_SPEED10 = 1;
   localparam int SUM_LINK = 0;

   ////////////////////////////////////////////////////////////////////////////
   // interrupt control fields
   localparam int CTL_W = 3;
   localparam int CTL_TEST = 2;
   localparam int CTL_GATE = 1;
   localparam int CTL_PIN_ROLE = 0;
   localparam logic [2:0] CTL_RESET = 3'h0;

   // event status register: status in 14:8, enables in 6:0
   localparam int EVT_COUNT = 7;
   localparam int EVT_STAT_LSB = 8;
   localparam int EVT_EN_LSB = 0;
   localparam logic [6:0] EVT_EN_RESET = 7'h00;
   localparam int EV_RX_HALF = 0;
   localparam int EV_FC_HALF = 1;
   localparam int EV_AN_DONE = 2;
   localparam int EV_DUPLEX = 3;
   localparam int EV_SPEED = 4;
   localparam int EV_LINK = 5;
   localparam int EV_ENERGY = 6;

   // configuration and expansion fields
   localparam int CFG_SIG_DET_QUAL_BIT = 8;
   localparam logic CFG_SIG_DET_QUAL_RESET = 1'b0;
   localparam int ANEG_PAGE_BIT = 1;
endpackage

// ===== hdl/level_sync.sv
// Purpose: two flip-flop synchroniser for levels arriving from pins
// Assumes: inputs are slow levels, not pulses
// Notes: the first stage feeds only the second stage
`timescale 1ns/1ns
module level_sync #(
   parameter int WIDTH = 1
) (
   input wire logic i_ref_clk,              // system clock
   input wire logic i_rst_n,                // async reset, active low
   input wire logic [WIDTH-1:0] i_async,    // raw level from outside
   output logic [WIDTH-1:0] o_sync          // level safe to use
);
   logic [WIDTH-1:0] stage1_reg;
   logic [WIDTH-1:0] stage2_reg;

   // metastability guard, second stage only is read
   always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         stage1_reg <= '0;
         stage2_reg <= '0;
      end else begin
         stage1_reg <= i_async;
         stage2_reg <= stage1_reg;
      end
   end

   assign o_sync = stage2_reg;
endmodule

// ===== hdl/phy_status_and_irq_control.sv
// Purpose: status summary word, interrupt control word and event interrupt bank
// Assumes: status and event inputs come from logic on i_ref_clk
// Notes: the shared pin is driven only when the pin role selects interrupt output
//
// Decided for this implementation: strobed register access and the placing of the registers.
`timescale 1ns/1ns
// Notes on behaviour
// - bit 10 latched-low qualified signal detect
// - bit 9 latched-low descrambler lock, reset zero
// - bit 8 page received, cleared by expansion read
// - bit 7 pending interrupt, event read clears unless the test bit is set
// - bit 6 remote fault, cleared by basic mode status read
// - bit 5 mirrors jabber flag, not cleared
// - bit 4 auto-negotiation complete
// - bit 3 loopback enabled
// - bit 2 full duplex result
// - bit 1 reads one for 10 Mb/s
// - bit 0 mirrors link flag, not cleared
// - control bits 15:3 read zero, ignore writes
// - test bit forces interrupt continuously
// - global gate enables event based interrupts
// - pin role: interrupt output or power-down input
// - seven event sources, each individually enabled
// - reading event register clears event bits
// - event bits set regardless of enables
// - low seven event register bits are enables
module phy_status_and_irq_control
   import phy_status_pkg::*;
(
   input wire logic i_ref_clk,                  // 25 MHz clock
   input wire logic i_rst_n,                    // async reset, active low
   input wire logic [ADDR_W-1:0] i_addr,        // register index
   input wire logic [DATA_W-1:0] i_wr_data,     // write data
   input wire logic i_wr_stb,                   // one-cycle write strobe
   input wire logic i_rd_stb,                   // one-cycle read strobe
   output logic [DATA_W-1:0] o_rd_data,         // read data, cycle after strobe
   input wire logic i_raw_sig_det,              // raw signal detect
   input wire logic i_descr_lock,               // descrambler lock
   input wire logic i_page_rx_pulse,            // new link code word page
   input wire logic i_rem_fault_pulse,          // partner remote fault seen
   input wire logic i_jabber,                   // jabber flag level
   input wire logic i_an_done,                  // auto-negotiation complete level
   input wire logic i_loopback,                 // loopback enabled level
   input wire logic i_full_duplex,              // duplex result, 1 full
   input wire logic i_speed10,                  // speed result, 1 means 10 Mb/s
   input wire logic i_link_up,                  // link flag level
   input wire logic i_energy_change,            // energy detect change pulse
   input wire logic i_fc_half_full,             // false carrier counter half full
   input wire logic i_rx_half_full,             // receive error counter half full
   input wire logic i_pd_irq_pin,               // shared pin level in
   output logic o_pd_irq_pin,                   // shared pin drive, low = interrupt
   output logic o_pd_irq_oe,                    // shared pin output enable
   output logic o_power_down,                   // power-down request from pin
   output logic o_sig_det_qualified             // qualified signal detect to link monitor
);
   ////////////////////////////////////////////////////////////////////////////
   // register state
   logic [CTL_W-1:0] ctl_reg, ctl_next;
   logic [EVT_COUNT-1:0] evt_en_reg, evt_en_next;
   logic [EVT_COUNT-1:0] evt_reg, evt_next;
   logic cfg_sig_det_qual_reg, cfg_sig_det_qual_next;
   logic sig_det_latch_reg, sig_det_latch_next;
   logic lock_latch_reg, lock_latch_next;
   logic page_reg, page_next;
   logic rf_reg, rf_next;
   logic [5:0] prev_reg;
   logic [DATA_W-1:0] rd_data_reg, rd_data_next;
   logic pin_out_reg, pin_oe_reg, power_down_reg, sig_det_out_reg;
   logic pd_pin_sync;

   // pin level crosses into the clock domain before use
   level_sync #(.WIDTH(1)) u_pin_sync (
      .i_ref_clk(i_ref_clk),
      .i_rst_n(i_rst_n),
      .i_async(i_pd_irq_pin),
      .o_sync(pd_pin_sync)
   );

   ////////////////////////////////////////////////////////////////////////////
   // address decode
   wire rd_sum = i_rd_stb && (i_addr == ADDR_STATUS_SUMMARY);
   wire rd_evt = i_rd_stb && (i_addr == ADDR_INTERRUPT_EVENT_STATUS);
   wire rd_aneg = i_rd_stb && (i_addr == ADDR_AUTONEG_EXPANSION);
   wire rd_bms = i_rd_stb && (i_addr == ADDR_BASIC_MODE_STATUS);
   wire wr_ctl = i_wr_stb && (i_addr == ADDR_INTERRUPT_CONTROL);
   wire wr_evt = i_wr_stb && (i_addr == ADDR_INTERRUPT_EVENT_STATUS);
   wire wr_cfg = i_wr_stb && (i_addr == ADDR_PHY_CONFIG);

   // qualified signal detect: lock only counts when configured in
   wire sig_det_live = i_raw_sig_det & (cfg_sig_det_qual_reg ? i_descr_lock : 1'b1);

   // latched-low: a drop sticks until the summary is read, then reload live
   assign sig_det_latch_next = rd_sum ? sig_det_live : (sig_det_latch_reg & sig_det_live);
   assign lock_latch_next = rd_sum ? i_descr_lock : (lock_latch_reg & i_descr_lock);

   // sticky flags, a new event in the clearing cycle wins
   assign page_next = i_page_rx_pulse | (page_reg & ~rd_aneg);
   assign rf_next = i_rem_fault_pulse | (rf_reg & ~rd_bms);

   ////////////////////////////////////////////////////////////////////////////
   // event detection: changes of link, speed and duplex, rising edges of auto-negotiation complete and half-full
   wire [5:0] cur_lvl = {i_link_up, i_speed10, i_full_duplex, i_an_done, i_fc_half_full, i_rx_half_full};
   wire [EVT_COUNT-1:0] ev_hit;
   assign ev_hit[EV_ENERGY] = i_energy_change;
   assign ev_hit[EV_LINK] = cur_lvl[5] ^ prev_reg[5];
   assign ev_hit[EV_SPEED] = cur_lvl[4] ^ prev_reg[4];
   assign ev_hit[EV_DUPLEX] = cur_lvl[3] ^ prev_reg[3];
   assign ev_hit[EV_AN_DONE] = cur_lvl[2] & ~prev_reg[2];
   assign ev_hit[EV_FC_HALF] = cur_lvl[1] & ~prev_reg[1];
   assign ev_hit[EV_RX_HALF] = cur_lvl[0] & ~prev_reg[0];

   // events latch whatever the enables say; a read acknowledges them all
   assign evt_next = ev_hit | (evt_reg & {EVT_COUNT{~rd_evt}});

   ////////////////////////////////////////////////////////////////////////////
   // interrupt generation
   wire enabled_pending = |(evt_reg & evt_en_reg);
   wire event_irq = ctl_reg[CTL_GATE] & enabled_pending;
   wire irq_pend = ctl_reg[CTL_TEST] | event_irq;
   wire pin_assert = ctl_reg[CTL_PIN_ROLE] & irq_pend;

   // writable fields; reserved control bits are simply not stored
   assign ctl_next = wr_ctl ? i_wr_data[CTL_W-1:0] : ctl_reg;
   assign evt_en_next = wr_evt ? i_wr_data[EVT_EN_LSB +: EVT_COUNT] : evt_en_reg;
   assign cfg_sig_det_qual_next = wr_cfg ? i_wr_data[CFG_SIG_DET_QUAL_BIT] : cfg_sig_det_qual_reg;

   ////////////////////////////////////////////////////////////////////////////
   // read words
   wire [DATA_W-1:0] sum_word;
   assign sum_word[DATA_W-1:SUM_SIG_DET_QUAL+1] = '0;
   assign sum_word[SUM_SIG_DET_QUAL] = sig_det_latch_reg;
   assign sum_word[SUM_DESCR_LOCK] = lock_latch_reg;
   assign sum_word[SUM_PAGE_RX] = page_reg;
   assign sum_word[SUM_IRQ_PEND] = irq_pend;
   assign sum_word[SUM_REM_FAULT] = rf_reg;
   assign sum_word[SUM_JABBER] = i_jabber;
   assign sum_word[SUM_AN_DONE] = i_an_done;
   assign sum_word[SUM_LOOPBACK] = i_loopback;
   assign sum_word[SUM_DUPLEX] = i_full_duplex;
   assign sum_word[SUM_SPEED10] = i_speed10;
   assign sum_word[SUM_LINK] = i_link_up;

   wire [DATA_W-1:0] ctl_word = {{(DATA_W-CTL_W){1'b0}}, ctl_reg};
   wire [DATA_W-1:0] evt_word = {1'b0, evt_reg, 1'b0, evt_en_reg};
   wire [DATA_W-1:0] cfg_word = {{(DATA_W-CFG_SIG_DET_QUAL_BIT-1){1'b0}}, cfg_sig_det_qual_reg,
                                 {CFG_SIG_DET_QUAL_BIT{1'b0}}};

   // other indices answer zero here; the expansion and basic status words
   // live elsewhere, this block only watches their reads
   wire [DATA_W-1:0] rd_word = (i_addr == ADDR_STATUS_SUMMARY) ? sum_word :
                               (i_addr == ADDR_INTERRUPT_CONTROL) ? ctl_word :
                               (i_addr == ADDR_INTERRUPT_EVENT_STATUS) ? evt_word :
                               (i_addr == ADDR_PHY_CONFIG) ? cfg_word : '0;
   assign rd_data_next = i_rd_stb ? rd_word : '0;

   ////////////////////////////////////////////////////////////////////////////
   // register bank state
   always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         ctl_reg <= CTL_RESET;
         evt_en_reg <= EVT_EN_RESET;
         evt_reg <= '0;
         cfg_sig_det_qual_reg <= CFG_SIG_DET_QUAL_RESET;
      end else begin
         ctl_reg <= ctl_next;
         evt_en_reg <= evt_en_next;
         evt_reg <= evt_next;
         cfg_sig_det_qual_reg <= cfg_sig_det_qual_next;
      end
   end

   // status flags and change detectors
   always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         sig_det_latch_reg <= 1'b0;
         lock_latch_reg <= 1'b0;
         page_reg <= 1'b0;
         rf_reg <= 1'b0;
         prev_reg <= '0;
      end else begin
         sig_det_latch_reg <= sig_det_latch_next;
         lock_latch_reg <= lock_latch_next;
         page_reg <= page_next;
         rf_reg <= rf_next;
         prev_reg <= cur_lvl;
      end
   end

   // output flops; pin idles high and undriven so the power-down input is free
   always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         rd_data_reg <= '0;
         pin_out_reg <= 1'b1;
         pin_oe_reg <= 1'b0;
         power_down_reg <= 1'b0;
         sig_det_out_reg <= 1'b0;
      end else begin
         rd_data_reg <= rd_data_next;
         pin_out_reg <= ~pin_assert;
         pin_oe_reg <= ctl_reg[CTL_PIN_ROLE];
         power_down_reg <= ~ctl_reg[CTL_PIN_ROLE] & ~pd_pin_sync;
         sig_det_out_reg <= sig_det_live;
      end
   end

   assign o_rd_data = rd_data_reg;
   assign o_pd_irq_pin = pin_out_reg;
   assign o_pd_irq_oe = pin_oe_reg;
   assign o_power_down = power_down_reg;
   assign o_sig_det_qualified = sig_det_out_reg;

   ////////////////////////////////////////////////////////////////////////////
   // checks on the bank behaviour
   default clocking cb @(posedge i_ref_clk); endclocking
   default disable iff (!i_rst_n);

   sum_live_bits_a: assert property (rd_sum |=> o_rd_data[5:0] == $past(sum_word[5:0]))
      else $error("summary low bits do not match live status");
   sum_mirror_a: assert property (rd_sum |=> (o_rd_data[SUM_LINK] == $past(i_link_up)) &&
         (o_rd_data[SUM_SPEED10] == $past(i_speed10)) && (o_rd_data[SUM_JABBER] == $past(i_jabber)))
      else $error("summary mirror bits wrong");
   sig_det_low_a: assert property ((!sig_det_latch_reg && !rd_sum) |=> !sig_det_latch_reg)
      else $error("latched-low signal detect rose without a summary read");
   lock_reload_a: assert property (rd_sum |=> lock_latch_reg == $past(i_descr_lock))
      else $error("descrambler lock latch not reloaded on read");
   page_hold_a: assert property ((page_reg && !rd_aneg) |=> page_reg)
      else $error("page received cleared without expansion read");
   page_clear_a: assert property ((rd_aneg && !i_page_rx_pulse) |=> !page_reg)
      else $error("page received not cleared by expansion read");
   fault_clear_a: assert property ((rd_bms && !i_rem_fault_pulse) |=> !rf_reg ##1 (rf_reg == $past(i_rem_fault_pulse)))
      else $error("remote fault clear wrong");
   evt_set_a: assert property ((ev_hit != '0) |=> ((evt_reg & $past(ev_hit)) == $past(ev_hit)))
      else $error("event bit missed");
   evt_ack_a: assert property ((rd_evt && ev_hit == '0) |=> evt_reg == '0)
      else $error("event read did not clear events");
   ctl_zero_a: assert property (i_rd_stb && i_addr == ADDR_INTERRUPT_CONTROL |=> o_rd_data[15:3] == '0)
      else $error("control reserved bits not zero");
   test_force_a: assert property ((ctl_reg[CTL_TEST] && ctl_reg[CTL_PIN_ROLE] && !wr_ctl) |=> !o_pd_irq_pin ##1 !o_pd_irq_pin)
      else $error("test interrupt not driven");
   gate_off_a: assert property ((!ctl_reg[CTL_TEST] && !ctl_reg[CTL_GATE]) |=> o_pd_irq_pin)
      else $error("interrupt raised while gated off");
   pin_role_a: assert property (o_pd_irq_oe |-> $past(ctl_reg[CTL_PIN_ROLE]))
      else $error("pin driven while role is input");
endmodule

// ===== bench/mgmt_master.sv
// Purpose: management controller model on the plain register port
// Assumes: read data stands only in the cycle after the read strobe
// Notes: each access starts with an idle cycle, so strobes never overlap
`timescale 1ns/1ns
module mgmt_master
   import phy_status_pkg::*;
(
   input wire logic i_ref_clk,               // clock
   input wire logic [DATA_W-1:0] i_rd_data,  // read data from the bank
   output logic [ADDR_W-1:0] o_addr,         // register index
   output logic [DATA_W-1:0] o_wr_data,      // write data
   output logic o_wr_stb,                    // write strobe
   output logic o_rd_stb                     // read strobe
);
   // idle bus from time zero
   initial begin
      o_addr = 5'h00;
      o_wr_data = 16'h0000;
      o_wr_stb = 1'b0;
      o_rd_stb = 1'b0;
   end
   // one-cycle write, signals move only just after an edge
   task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
      @(posedge i_ref_clk);
      o_addr <= a;
      o_wr_data <= d;
      o_wr_stb <= 1'b1;
      @(posedge i_ref_clk);
      o_wr_stb <= 1'b0;
   endtask
   // data is taken mid answer cycle, where it is settled, then the cycle is closed
   task automatic rd(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] d);
      @(posedge i_ref_clk);
      o_addr <= a;
      o_rd_stb <= 1'b1;
      @(posedge i_ref_clk);
      o_rd_stb <= 1'b0;
      @(negedge i_ref_clk);
      d = i_rd_data;
      @(posedge i_ref_clk);
   endtask
endmodule

// ===== bench/phy_status_and_irq_control_tb.sv
// Purpose: self-checking bench for the status summary and interrupt bank
// Assumes: event-to-pin takes two cycles, so three-cycle waits are safe
// Notes: src bits 5:0 and 10:9 line up with summary bit positions
`timescale 1ns/1ns
module phy_status_and_irq_control_tb;
   import phy_status_pkg::*;
   logic i_ref_clk = 1'b0;
   logic i_rst_n = 1'b0;
   logic [13:0] src = 14'h2000;
   logic [4:0] addr;
   logic [15:0] wdata;
   logic [15:0] rdata;
   logic wr_stb;
   logic rd_stb;
   logic pin_o;
   logic pin_oe;
   logic pwr_dn;
   logic sig_det_q;
   int n_errors = 0;
   int n_tests = 0;
   // shared pin: bank drives when enabled, else the outside pull-up or src[13]
   wire pin_lvl = pin_oe ? pin_o : src[13];

   always #20 i_ref_clk = ~i_ref_clk;

   phy_status_and_irq_control phy_status_and_irq_control_inst (.i_ref_clk(i_ref_clk), .i_rst_n(i_rst_n),
      .i_addr(addr), .i_wr_data(wdata), .i_wr_stb(wr_stb), .i_rd_stb(rd_stb), .o_rd_data(rdata),
      .i_raw_sig_det(src[10]), .i_descr_lock(src[9]), .i_page_rx_pulse(src[8]), .i_rem_fault_pulse(src[6]),
      .i_jabber(src[5]), .i_an_done(src[4]), .i_loopback(src[3]), .i_full_duplex(src[2]),
      .i_speed10(src[1]), .i_link_up(src[0]), .i_energy_change(src[7]), .i_fc_half_full(src[11]),
      .i_rx_half_full(src[12]), .i_pd_irq_pin(pin_lvl), .o_pd_irq_pin(pin_o), .o_pd_irq_oe(pin_oe),
      .o_power_down(pwr_dn), .o_sig_det_qualified(sig_det_q));
   mgmt_master mgmt_master_inst (.i_ref_clk(i_ref_clk), .i_rd_data(rdata), .o_addr(addr),
      .o_wr_data(wdata), .o_wr_stb(wr_stb), .o_rd_stb(rd_stb));

   ////////////////////////////////////////////////////////////////////////////
   // helpers
   task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
      n_tests++;
      if (got !== exp) begin
         n_errors++;
         $display("MISMATCH %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic rdchk(input logic [4:0] a, input logic [15:0] exp);
      logic [15:0] d;
      mgmt_master_inst.rd(a, d);
      chk($sformatf("reg %h", a), exp, d);
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge i_ref_clk);
   endtask
   task automatic set(input int i, input logic v);
      @(posedge i_ref_clk);
      src[i] <= v;
   endtask
   // pulse lasts exactly one cycle
   task automatic pulse(input int i);
      set(i, 1'b1);
      set(i, 1'b0);
   endtask
   task automatic results();
      $display("tests %0d mismatches %0d", n_tests, n_errors);
      if (n_errors == 0 && n_tests > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask

   ////////////////////////////////////////////////////////////////////////////
   // scenarios
   task automatic t_reset();
      rdchk(5'h11, 16'h0000);
      rdchk(5'h12, 16'h0000);
      chk("oe", 16'h0000, {15'h0, pin_oe});
      chk("pin", 16'h0001, {15'h0, pin_o});
      $display("done reset");
   endtask
   // levels land in the summary; speed and duplex read as driven, with link held up
   task automatic t_status();
      logic [15:0] d;
      @(posedge i_ref_clk);
      src[10:0] <= 11'h63f;
      cyc(2);
      mgmt_master_inst.rd(5'h10, d);
      rdchk(5'h10, 16'h063f);
      rdchk(5'h10, 16'h063f);
      chk("sig_det", 16'h0001, {15'h0, sig_det_q});
      set(9, 1'b0);
      cyc(2);
      set(9, 1'b1);
      cyc(2);
      rdchk(5'h10, 16'h043f);
      rdchk(5'h10, 16'h063f);
      mgmt_master_inst.wr(5'h16, 16'h0100);
      set(9, 1'b0);
      cyc(3);
      chk("sig_det", 16'h0000, {15'h0, sig_det_q});
      rdchk(5'h10, 16'h003f);
      set(9, 1'b1);
      mgmt_master_inst.wr(5'h16, 16'h0000);
      cyc(2);
      mgmt_master_inst.rd(5'h10, d);
      pulse(8);
      pulse(6);
      rdchk(5'h10, 16'h077f);
      rdchk(5'h10, 16'h077f);
      mgmt_master_inst.rd(5'h01, d);
      rdchk(5'h10, 16'h073f);
      mgmt_master_inst.rd(5'h06, d);
      rdchk(5'h10, 16'h063f);
      $display("done status");
   endtask
   task automatic t_irq();
      logic [15:0] d;
      mgmt_master_inst.rd(5'h12, d);
      mgmt_master_inst.wr(5'h12, 16'h0020);
      mgmt_master_inst.wr(5'h11, 16'hffff);
      rdchk(5'h11, 16'h0007);
      cyc(3);
      chk("oe", 16'h0001, {15'h0, pin_oe});
      chk("pin", 16'h0000, {15'h0, pin_o});
      cyc(5);
      chk("pin", 16'h0000, {15'h0, pin_o});
      mgmt_master_inst.wr(5'h11, 16'h0003);
      cyc(3);
      chk("pin", 16'h0001, {15'h0, pin_o});
      pulse(7);
      cyc(3);
      chk("pin", 16'h0001, {15'h0, pin_o});
      rdchk(5'h12, 16'h4020);
      rdchk(5'h12, 16'h0020);
      set(0, 1'b0);
      cyc(3);
      chk("pin", 16'h0000, {15'h0, pin_o});
      rdchk(5'h10, 16'h06be);
      rdchk(5'h12, 16'h2020);
      cyc(3);
      chk("pin", 16'h0001, {15'h0, pin_o});
      mgmt_master_inst.wr(5'h11, 16'h0001);
      set(0, 1'b1);
      cyc(3);
      chk("pin", 16'h0001, {15'h0, pin_o});
      rdchk(5'h12, 16'h2020);
      mgmt_master_inst.wr(5'h12, 16'h0003);
      mgmt_master_inst.wr(5'h11, 16'h0003);
      @(posedge i_ref_clk);
      src[12:11] <= 2'b11;
      cyc(3);
      chk("pin", 16'h0000, {15'h0, pin_o});
      rdchk(5'h12, 16'h0303);
      mgmt_master_inst.wr(5'h11, 16'h0000);
      set(13, 1'b0);
      cyc(4);
      chk("oe", 16'h0000, {15'h0, pin_oe});
      chk("pdown", 16'h0001, {15'h0, pwr_dn});
      set(13, 1'b1);
      $display("done irq");
   endtask

   ////////////////////////////////////////////////////////////////////////////
   // main sequence
   initial begin
      cyc(12);
      i_rst_n <= 1'b1;
      t_reset();
      t_status();
      t_irq();
      results();
   end
   // watchdog: the tests need well under a thousand cycles
   initial begin
      cyc(5000);
      n_errors++;
      results();
   end
endmodule
